// ### hw/bmio_pkg.sv
/*
  Package for the bus-muxed I/O ports: register indices, banks, reset values,
  operating modes, bus timing and the packed carriers shared by the design.
  Assumes a 100 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package bmio_pkg;

  localparam int unsigned AVS_AW = 8;
  localparam int unsigned AVS_DW = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_LOW_DIR    = 6'h10;
  localparam logic [5:0] IDX_LOW_DATA   = 6'h11;
  localparam logic [5:0] IDX_HIGH_DIR   = 6'h12;
  localparam logic [5:0] IDX_HIGH_DATA  = 6'h13;
  localparam logic [5:0] IDX_THIRD_DIR  = 6'h11;
  localparam logic [5:0] IDX_THIRD_DATA = 6'h12;
  localparam logic [5:0] IDX_MODE       = 6'h0e;
  localparam logic [5:0] IDX_BANK       = 6'h0f;

  localparam logic [3:0] BANK_THIRD     = 4'h0;
  localparam logic [3:0] BANK_BUS_PORTS = 4'h1;

  localparam logic [7:0] DIR_RESET   = 8'hff;
  localparam logic [7:0] LATCH_POR   = 8'h00;
  localparam logic [3:0] BANK_POR    = 4'h0;
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned BUSY_BIT   = 7;

  typedef enum logic [1:0] {
    MODE_MICROPROCESSOR = 2'h0,
    MODE_EXT_MCU        = 2'h1,
    MODE_MCU            = 2'h2,
    MODE_PROT_MCU       = 2'h3
  } bmio_mode_t;

  localparam bmio_mode_t MODE_POR = MODE_MCU;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BUS_PHASE_NS  = 30;
  localparam int unsigned BUS_PHASE_CYC = (BUS_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bmio_xreq_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } bmio_pins_t;

  typedef struct packed {
    logic ale;
    logic oe_n;
    logic wr_n;
    logic en;
  } bmio_ctl_t;

endpackage

// ### hw/bmio_pin_cell.sv
/*
  One port of bidirectional pins: registers the drive value and enable, and
  brings the pin levels into the clock domain through two flip-flops.
  Assumes the surrounding pad or bench resolves the wire from the enables.
*/
`timescale 1ns/1ps
module bmio_pin_cell #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_pin,
  input  wire logic [W-1:0] i_drive_val,
  input  wire logic [W-1:0] i_drive_en,
  output logic      [W-1:0] o_out,
  output logic      [W-1:0] o_oe,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] meta_q;

  // Enables come up low so that every pin floats until the registers say otherwise.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_out   <= '0;
      o_oe    <= '0;
      meta_q  <= '0;
      o_level <= '0;
    end else begin
      o_out   <= i_drive_val;
      o_oe    <= i_drive_en;
      meta_q  <= i_pin;
      o_level <= meta_q;
    end
  end

endmodule

// ### hw/bmio_top.sv
/*
  Bus-muxed I/O ports: three 8-bit general ports reached over Avalon-MM,
  two of which become the multiplexed address/data bus in the bus modes,
  with a small sequencer driving the bus-control pins.
  Assumes a single 100 MHz clock, power-on reset on i_arst_n, and that
  pins arrive asynchronously.
*/
// Notes on behaviour
// [RULE1] Low-byte port has eight pins, each an input or an output.
// [RULE2] Low-byte direction bit 1 means input, 0 means driven output.
// [RULE3] Low-byte data read returns pin levels; write loads the output latch.
// [RULE4] High-byte port has eight pins with individual direction control.
// [RULE5] High-byte direction bit 1 means input, 0 means output.
// [RULE6] High-byte data read samples pins; write loads the latch.
// [RULE7] In bus operation the low-byte pins carry bus bits 7 to 0.
// [RULE8] In bus operation the high-byte pins carry bus bits 15 to 8.
// [RULE9] Microprocessor and extended microcontroller modes turn both ports into the bus.
// [RULE10] The two microcontroller modes leave both ports as plain I/O.
// [RULE11] Every pin of both ports serves as I/O or as one bus bit.
// [RULE12] Low-byte direction resets to all ones on every kind of reset.
// [RULE13] Pin and watchdog resets set directions but keep data latches.
// [RULE14] Software selects bank 1 before touching the bus-capable port registers.
// [RULE15] Third port direction bit 1 means input, 0 means output.
// [RULE16] Third port read returns pins; write loads its latch.
// [RULE17] Bus modes drive address latch strobe, low output enable, low write strobe.
// [RULE18] In bus operation the sequencer, not the registers, drives the pins.
// [RULE19] Software clears a latch before turning its pins into outputs.
`timescale 1ns/1ps
module bmio_top (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_ext_reset_pin_n,
  input  wire logic                      i_wdt_timeout,
  input  wire logic [bmio_pkg::AVS_AW-1:0] i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [bmio_pkg::AVS_DW-1:0] i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output logic      [bmio_pkg::AVS_DW-1:0] o_avs_readdata,
  output logic                           o_avs_waitrequest,
  input  wire logic                      i_xbus_valid,
  input  wire bmio_pkg::bmio_xreq_t      i_xbus_req,
  output logic                           o_xbus_ready,
  output logic                           o_xbus_rvalid,
  output logic      [15:0]               o_xbus_rdata,
  input  wire logic [7:0]                i_low_pins,
  output bmio_pkg::bmio_pins_t           o_low,
  input  wire logic [7:0]                i_high_pins,
  output bmio_pkg::bmio_pins_t           o_high,
  input  wire logic [7:0]                i_third_pins,
  output bmio_pkg::bmio_pins_t           o_third,
  output bmio_pkg::bmio_ctl_t            o_bus_ctl
);
  import bmio_pkg::*;

  localparam logic [1:0] PH_LAST = 2'(BUS_PHASE_CYC - 1);

  typedef enum logic [1:0] {SQ_IDLE, SQ_ADDR, SQ_DATA} bmio_sq_t;

  ////////////////////////////////////////////////////////////////////////////
  // Non-power-up reset: external pin (synchronised) or watchdog pulse.

  logic rst_meta_q;
  logic rst_sync_q;
  wire  soft_rst = ~rst_sync_q | i_wdt_timeout;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end else begin
      rst_meta_q <= i_ext_reset_pin_n;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle on every access.

  function automatic logic reg_hit(input logic [5:0] idx, input logic [5:0] want,
                                   input logic banked, input logic [3:0] bank,
                                   input logic [3:0] need);
    reg_hit = (idx == want) && (!banked || bank == need);
  endfunction

  logic        ack_q;
  logic [31:0] rdata_q;
  logic [3:0]  bank_q;
  bmio_mode_t  mode_q;
  logic [7:0]  low_dir_q, high_dir_q, third_dir_q;
  logic [7:0]  low_lat_q, high_lat_q, third_lat_q;
  logic [7:0]  low_lvl, high_lvl, third_lvl;
  bmio_sq_t    sq_q, sq_d;

  wire       req    = i_avs_read | i_avs_write;
  wire [5:0] idx    = i_avs_address[7:2];
  wire       wr_go  = i_avs_write & ack_q & i_avs_byteenable[0];
  wire [7:0] wbyte  = i_avs_writedata[7:0];
  // Bus-capable port registers only answer in bank 1, the third port in bank 0.
  wire hit_low_dir   = reg_hit(idx, IDX_LOW_DIR, 1'b1, bank_q, BANK_BUS_PORTS);   // [RULE14]
  wire hit_low_data  = reg_hit(idx, IDX_LOW_DATA, 1'b1, bank_q, BANK_BUS_PORTS);  // [RULE14]
  wire hit_high_dir  = reg_hit(idx, IDX_HIGH_DIR, 1'b1, bank_q, BANK_BUS_PORTS);
  wire hit_high_data = reg_hit(idx, IDX_HIGH_DATA, 1'b1, bank_q, BANK_BUS_PORTS);
  wire hit_third_dir = reg_hit(idx, IDX_THIRD_DIR, 1'b1, bank_q, BANK_THIRD);
  wire hit_third_dat = reg_hit(idx, IDX_THIRD_DATA, 1'b1, bank_q, BANK_THIRD);
  wire hit_mode      = reg_hit(idx, IDX_MODE, 1'b0, bank_q, BANK_POR);
  wire hit_bank      = reg_hit(idx, IDX_BANK, 1'b0, bank_q, BANK_POR);

  wire bus_mode = (mode_q == MODE_MICROPROCESSOR) || (mode_q == MODE_EXT_MCU); // [RULE9]

  wire [7:0] mode_rd = {sq_q != SQ_IDLE, 5'h00, mode_q};
  // Data reads return pin levels, never the latch.
  wire [7:0] rd_byte = hit_low_dir   ? low_dir_q   :
                       hit_low_data  ? low_lvl     : // [RULE3]
                       hit_high_dir  ? high_dir_q  :
                       hit_high_data ? high_lvl    : // [RULE6]
                       hit_third_dir ? third_dir_q :
                       hit_third_dat ? third_lvl   : // [RULE16]
                       hit_mode      ? mode_rd     :
                       hit_bank      ? {4'h0, bank_q} : 8'h00;

  assign o_avs_waitrequest = req & ~ack_q;
  assign o_avs_readdata    = rdata_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req & ~ack_q;
      if (i_avs_read && !ack_q) begin
        rdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers. Directions return to all ones on any reset; latches survive
  // the pin and watchdog resets so outputs resume their old values.

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_dir_q   <= DIR_RESET; // [RULE12]
      high_dir_q  <= DIR_RESET;
      third_dir_q <= DIR_RESET;
      bank_q      <= BANK_POR;
      mode_q      <= MODE_POR;
    end else if (soft_rst) begin
      low_dir_q   <= DIR_RESET; // [RULE12] [RULE13]
      high_dir_q  <= DIR_RESET;
      third_dir_q <= DIR_RESET;
      bank_q      <= BANK_POR;
    end else if (wr_go) begin
      if (hit_low_dir)   low_dir_q   <= wbyte;
      if (hit_high_dir)  high_dir_q  <= wbyte;
      if (hit_third_dir) third_dir_q <= wbyte;
      if (hit_bank)      bank_q      <= wbyte[3:0];
      if (hit_mode)      mode_q      <= bmio_mode_t'(wbyte[MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_lat_q   <= LATCH_POR;
      high_lat_q  <= LATCH_POR;
      third_lat_q <= LATCH_POR;
    end else if (wr_go && !soft_rst) begin // [RULE13]
      if (hit_low_data)  low_lat_q   <= wbyte; // [RULE3]
      if (hit_high_data) high_lat_q  <= wbyte; // [RULE6]
      if (hit_third_dat) third_lat_q <= wbyte; // [RULE16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External bus sequencer: address phase with the latch strobe, then a
  // data phase with the read or write strobe, each BUS_PHASE_CYC long.

  bmio_xreq_t xreq_q;
  logic [1:0] ph_q;
  bmio_ctl_t  ctl_q;
  logic       rvalid_q;
  logic       cap_q;
  logic [15:0] xrdata_q;

  wire tick = (ph_q == PH_LAST);
  // Read data reach us through the two pin synchroniser flops, so the capture
  // and the return of ready wait one cycle past the last read phase.
  assign o_xbus_ready = bus_mode && (sq_q == SQ_IDLE) && !cap_q;

  always_comb begin
    sq_d = sq_q;
    unique case (sq_q)
      SQ_IDLE: if (i_xbus_valid && o_xbus_ready) sq_d = SQ_ADDR;
      SQ_ADDR: if (tick) sq_d = SQ_DATA;
      SQ_DATA: if (tick) sq_d = SQ_IDLE;
    endcase
    if (!bus_mode) sq_d = SQ_IDLE; // [RULE10]
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sq_q     <= SQ_IDLE;
      ph_q     <= 2'h0;
      xreq_q   <= '0;
      ctl_q    <= '{ale: 1'b0, oe_n: 1'b1, wr_n: 1'b1, en: 1'b0};
      rvalid_q <= 1'b0;
      xrdata_q <= '0;
      cap_q    <= 1'b0;
    end else begin
      sq_q     <= sq_d;
      ph_q     <= (sq_d != sq_q) ? 2'h0 : ph_q + 2'h1;
      rvalid_q <= 1'b0;
      if (sq_q == SQ_IDLE && sq_d == SQ_ADDR) xreq_q <= i_xbus_req;
      ctl_q.ale  <= (sq_q == SQ_ADDR);                        // [RULE17]
      ctl_q.oe_n <= !(sq_q == SQ_DATA && !xreq_q.write);       // [RULE17]
      ctl_q.wr_n <= !(sq_q == SQ_DATA && xreq_q.write);        // [RULE17]
      ctl_q.en   <= bus_mode;
      cap_q    <= (sq_q == SQ_DATA) && tick && !xreq_q.write;
      if (cap_q) begin
        rvalid_q <= 1'b1;
        xrdata_q <= {high_lvl, low_lvl};
      end
    end
  end

  assign o_bus_ctl     = ctl_q;
  assign o_xbus_rvalid = rvalid_q;
  assign o_xbus_rdata  = xrdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive selection. In bus operation the low and high direction and latch registers
  // are bypassed; they keep their contents for the return to I/O mode.

  wire        ad_drv = (sq_q == SQ_ADDR) || (sq_q == SQ_DATA && xreq_q.write);
  wire [15:0] ad_val = (sq_q == SQ_ADDR) ? xreq_q.addr : xreq_q.wdata;

  wire [7:0] low_val   = bus_mode ? ad_val[7:0]  : low_lat_q;      // [RULE7] [RULE11]
  wire [7:0] low_en    = bus_mode ? {8{ad_drv}}  : ~low_dir_q;     // [RULE2] [RULE18]
  wire [7:0] high_val  = bus_mode ? ad_val[15:8] : high_lat_q;     // [RULE8] [RULE11]
  wire [7:0] high_en   = bus_mode ? {8{ad_drv}}  : ~high_dir_q;    // [RULE5] [RULE18]
  wire [7:0] third_en  = ~third_dir_q;                             // [RULE15]

  bmio_pin_cell #(.W(8)) u_low (                                   // [RULE1]
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin(i_low_pins),
    .i_drive_val(low_val), .i_drive_en(low_en),
    .o_out(o_low.out), .o_oe(o_low.oe), .o_level(low_lvl)
  );

  bmio_pin_cell #(.W(8)) u_high (                                  // [RULE4]
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin(i_high_pins),
    .i_drive_val(high_val), .i_drive_en(high_en),
    .o_out(o_high.out), .o_oe(o_high.oe), .o_level(high_lvl)
  );

  bmio_pin_cell #(.W(8)) u_third (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pin(i_third_pins),
    .i_drive_val(third_lat_q), .i_drive_en(third_en),
    .o_out(o_third.out), .o_oe(o_third.oe), .o_level(third_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  chk_low_dir_reset: assert property ( // [RULE12]
    soft_rst |=> low_dir_q == 8'hff)
    else $error("low-byte direction not all ones after reset");

  chk_latch_retain: assert property ( // [RULE13]
    soft_rst |=> low_lat_q == $past(low_lat_q) && high_lat_q == $past(high_lat_q))
    else $error("data latch changed on non-power reset");

  chk_low_gpio_oe: assert property ( // [RULE2]
    !$past(bus_mode) |-> o_low.oe == ~$past(low_dir_q) && o_low.out == $past(low_lat_q))
    else $error("low-byte pins not following direction and latch");

  chk_high_gpio_oe: assert property ( // [RULE5]
    !$past(bus_mode) |-> o_high.oe == ~$past(high_dir_q))
    else $error("high-byte pins not following direction");

  chk_third_oe: assert property ( // [RULE15]
    o_third.oe == ~$past(third_dir_q) && o_third.out == $past(third_lat_q))
    else $error("third port pins not following registers");

  chk_bus_owns_pins: assert property ( // [RULE18]
    $past(bus_mode) && $past(sq_q) == SQ_ADDR |->
      o_low.oe == 8'hff && {o_high.out, o_low.out} == $past(xreq_q.addr))
    else $error("address not driven on bus pins");

  chk_low_read_pins: assert property ( // [RULE3]
    i_avs_read && !ack_q && hit_low_data |=> o_avs_readdata == {24'h0, $past(low_lvl)})
    else $error("low-byte read did not return pin levels");

  sequence s_addr_phase;
    o_bus_ctl.ale [*3];
  endsequence

  sequence s_data_phase;
    !o_bus_ctl.ale && (!o_bus_ctl.oe_n ^ !o_bus_ctl.wr_n);
  endsequence

  chk_ale_then_strobe: assert property ( // [RULE17]
    @(posedge i_clk) disable iff (!i_arst_n || !bus_mode)
    $rose(o_bus_ctl.ale) |-> s_addr_phase ##1 s_data_phase)
    else $error("bus phase order broken");

  chk_gpio_no_bus: assert property ( // [RULE10]
    !bus_mode |-> !o_xbus_ready ##1 sq_q == SQ_IDLE)
    else $error("sequencer active outside bus mode");

endmodule

// ### dv/bmio_xmem.sv
/*
  Model of an external memory on the multiplexed address/data bus.
  Assumes the bench resolves the sixteen bus wires and feeds them back here.
*/
`timescale 1ns/1ps
module bmio_xmem (
  input  wire logic                i_clk,
  input  wire logic [15:0]         i_ad,
  input  wire bmio_pkg::bmio_ctl_t i_ctl,
  output logic      [15:0]         o_drv_val,
  output logic                     o_drv_en,
  output logic      [15:0]         o_addr_q
);
  import bmio_pkg::*;
  logic [15:0] mem_q [16];

  // The address is taken at every edge while the strobe is high, so the last sample wins.
  always @(posedge i_clk) begin
    if (i_ctl.en && i_ctl.ale) begin
      o_addr_q <= i_ad;
    end
    if (i_ctl.en && !i_ctl.wr_n) begin
      mem_q[o_addr_q[3:0]] <= i_ad;
    end
  end

  // Released the moment the output enable rises; the bench then floats a moving pattern.
  assign o_drv_en  = i_ctl.en && !i_ctl.oe_n;
  assign o_drv_val = mem_q[o_addr_q[3:0]];
endmodule

// ### dv/bmio_top_test.sv
/*
  Self-checking bench for the bus-muxed I/O ports: register tasks on Avalon-MM,
  core-side bus requests and resolved pin levels. Assumes the external memory model.
*/
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", what, exp, got); end end
module bmio_top_test;
  import bmio_pkg::*;
  localparam logic [5:0] DIR_IDX [3] = '{IDX_LOW_DIR, IDX_HIGH_DIR, IDX_THIRD_DIR};
  localparam logic [5:0] DAT_IDX [3] = '{IDX_LOW_DATA, IDX_HIGH_DATA, IDX_THIRD_DATA};
  logic        i_clk, i_arst_n, i_ext_reset_pin_n, i_wdt_timeout;
  logic [7:0]  i_avs_address;
  logic        i_avs_read, i_avs_write, i_xbus_valid, o_avs_waitrequest;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd;
  logic        o_xbus_ready, o_xbus_rvalid, mem_en, hold;
  logic [15:0] o_xbus_rdata, mem_val, mem_addr, got;
  bmio_xreq_t  i_xbus_req;
  bmio_pins_t  o_low, o_high, o_third;
  bmio_ctl_t   o_bus_ctl;
  logic [7:0]  ext [3];
  logic [7:0]  lvl_low, lvl_high, lvl_third;
  int          err_count, checks_done;

  assign lvl_low   = (o_low.oe & o_low.out) | (~o_low.oe & (mem_en ? mem_val[7:0] : ext[0]));
  assign lvl_high  = (o_high.oe & o_high.out) | (~o_high.oe & (mem_en ? mem_val[15:8] : ext[1]));
  assign lvl_third = (o_third.oe & o_third.out) | (~o_third.oe & ext[2]);

  bmio_top i_bmio_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ext_reset_pin_n(i_ext_reset_pin_n),
    .i_wdt_timeout(i_wdt_timeout), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_xbus_valid(i_xbus_valid), .i_xbus_req(i_xbus_req), .o_xbus_ready(o_xbus_ready),
    .o_xbus_rvalid(o_xbus_rvalid), .o_xbus_rdata(o_xbus_rdata), .i_low_pins(lvl_low),
    .o_low(o_low), .i_high_pins(lvl_high), .o_high(o_high), .i_third_pins(lvl_third),
    .o_third(o_third), .o_bus_ctl(o_bus_ctl));
  bmio_xmem i_bmio_xmem (.i_clk(i_clk), .i_ad({lvl_high, lvl_low}), .i_ctl(o_bus_ctl),
    .o_drv_val(mem_val), .o_drv_en(mem_en), .o_addr_q(mem_addr));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Undriven bus wires wander, so a stale value can never pass for a driven one.
  always @(posedge i_clk) begin
    if (!hold) begin
      ext[0] <= ext[0] + 8'h3b;
      ext[1] <= ~ext[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Requests change just after an edge and hold until waitrequest is seen low at one.
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd);
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= {24'h0, wd};
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic xbus(input logic w, input logic [15:0] a, input logic [15:0] d);
    i_xbus_req <= '{write: w, addr: a, wdata: d};
    i_xbus_valid <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_xbus_ready !== 1'b1);
    i_xbus_valid <= 1'b0;
    do begin
      @(posedge i_clk);
      if (o_xbus_rvalid === 1'b1) got = o_xbus_rdata;
    end while (o_xbus_ready !== 1'b1);
  endtask

  function automatic bmio_pins_t pins(input int p);
    return p == 0 ? o_low : (p == 1 ? o_high : o_third);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_arst_n, i_avs_read, i_avs_write, i_xbus_valid, i_wdt_timeout} = '0;
    {i_avs_address, i_avs_writedata, i_xbus_req} = '0;
    i_ext_reset_pin_n = 1'b1;
    hold = 1'b1;
    ext = '{8'h00, 8'h00, 8'h00};
    err_count = 0;
    checks_done = 0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    for (int p = 0; p < 3; p++) begin
      bus(1, IDX_BANK, p < 2 ? 8'(BANK_BUS_PORTS) : 8'(BANK_THIRD));
      bus(0, DIR_IDX[p], 8'h00);
      `CHK("dir reset", 32'hff, rd)
      bus(1, DAT_IDX[p], 8'h00);
      bus(1, DIR_IDX[p], 8'hcf);
      bus(1, DAT_IDX[p], 8'ha5);
      ext[p] <= 8'h5a;
      repeat (4) @(posedge i_clk);
      bus(0, DAT_IDX[p], 8'h00);
      `CHK("pin read", 32'h6a, rd)
      `CHK("pin oe", 8'h30, pins(p).oe)
      `CHK("pin out", 8'h20, pins(p).out & pins(p).oe)
    end
    bus(0, IDX_LOW_DIR, 8'h00);
    `CHK("wrong bank", 32'h0, rd)
    for (int k = 0; k < 2; k++) begin
      if (k == 0) i_wdt_timeout <= 1'b1;
      else i_ext_reset_pin_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_wdt_timeout <= 1'b0;
      i_ext_reset_pin_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      `CHK("soft oe", 8'h00, o_low.oe | o_third.oe)
      bus(0, IDX_BANK, 8'h00);
      `CHK("soft bank", 32'h0, rd)
      bus(1, IDX_BANK, 8'(BANK_BUS_PORTS));
      bus(1, IDX_LOW_DIR, 8'h00);
      `CHK("kept latch", 8'ha5, o_low.out)
    end
    hold = 1'b0;
    for (int m = 0; m < 2; m++) begin
      bus(1, IDX_MODE, 8'(m));
      xbus(1, 16'h5ac3 ^ 16'(m), 16'hbe00 | 16'(m));
      `CHK("bus addr", 16'h5ac3 ^ 16'(m), mem_addr)
      xbus(0, 16'h5ac3 ^ 16'(m), 16'h0000);
      `CHK("bus rdata", 16'hbe00 | 16'(m), got)
    end
    for (int m = 2; m < 4; m++) begin
      bus(1, IDX_MODE, 8'(m));
      repeat (2) @(posedge i_clk);
      `CHK("gpio ready", 1'b0, o_xbus_ready | o_bus_ctl.en)
      `CHK("gpio out", 16'hffa5, {o_low.oe, o_low.out})
      bus(0, IDX_MODE, 8'h00);
      `CHK("mode read", 32'(m), rd)
    end
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    complete_run();
  end
endmodule
